// *** logic/crbie_pkg.sv ***
// Package with register map, field positions and carrier types for the CRB interrupt block.
// Overview of operation
// - Global enable bit 31 low blocks all interrupts.
// - Four per-source enables, bits 3..0, reset 0.
// - Reserved enable and status bits read zero.
// - Owner field change sets status bit 3.
// - Grant from unassigned raises no owner interrupt.
// - Completed established reset sets status bit 2.
// - Leaving idle after ready request sets bit 1.
// - Command done, launch field cleared, sets bit 0.
// - Cancelling running command also sets bit 0.
// - Status resets 0; write 1 clears bit.
package crbie_pkg;

  localparam logic [7:0]  OFF_ENABLE    = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam int          BIT_GLOBAL    = 31;
  localparam int          BIT_OWNER     = 3;
  localparam int          BIT_ESTAB     = 2;
  localparam int          BIT_READY     = 1;
  localparam int          BIT_DONE      = 0;
  localparam int          NUM_SRC       = 4;
  localparam logic [31:0] ENABLE_RESET  = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] ENABLE_MASK   = 32'h8000_000f;
  localparam logic [31:0] STATUS_MASK   = 32'h0000_000f;
  localparam logic [3:0]  LAUNCH_CODE   = 4'h1;
  localparam logic [3:0]  LAUNCH_IDLE   = 4'h0;
  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    CMD_IDLE  = 2'h0,
    CMD_RUN   = 2'h1,
    CMD_ABORT = 2'h3
  } crbie_cmd_type;

  // Address phase of an accepted transfer, held for its data phase.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } crbie_req_type;

  // One bit per interrupt source, in status bit order 3..0.
  typedef struct packed {
    logic owner;
    logic estab;
    logic ready;
    logic done;
  } crbie_evt_type;

  function automatic logic crbie_hit(input crbie_req_type req, input logic [7:0] off);
    crbie_hit = req.valid && (req.addr == off);
  endfunction

endpackage

// *** logic/crbie_sticky_bit.sv ***
// One sticky pending flag: hardware set wins over a software clear.
`timescale 1ns/100ps
module crbie_sticky_bit (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      pend
);

  logic pend_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (set) begin
      pend_q <= 1'b1;
    end else if (clear) begin
      pend_q <= 1'b0;
    end
  end

  assign pend = pend_q;

endmodule

// *** logic/crbie_armed_event.sv ***
// Arms on a request pulse and fires once when the completion level is seen.
`timescale 1ns/100ps
module crbie_armed_event (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic arm,
  input  wire logic done,
  output logic      armed,
  output logic      fire
);

  logic armed_q;

  // A completion seen before the request is ignored; only the next one counts.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (arm) begin
      armed_q <= 1'b1;
    end else if (armed_q && done) begin
      armed_q <= 1'b0;
    end
  end

  assign armed = armed_q;
  assign fire  = armed_q && done;

endmodule

// *** logic/crbie_irq_ctrl.sv ***
// CRB interrupt enable and status registers with AHB-Lite slave and event capture.
`timescale 1ns/100ps
module crbie_irq_ctrl
  import crbie_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [2:0]  owner_field,
  input  wire logic        owner_assigned_flag,
  input  wire logic        established_flag,
  input  wire logic        established_reset_request,
  input  wire logic        go_ready_request,
  input  wire logic        idle_status,
  input  wire logic [3:0]  command_launch_field,
  input  wire logic        command_launch_write,
  input  wire logic        command_cancel,
  output logic             irq
);

  crbie_req_type req_q;
  logic [31:0]   enable_q;
  logic [31:0]   hrdata_q;
  logic          hreadyout_q;
  logic          hresp_q;
  logic          irq_q;
  logic [2:0]    owner_field_q;
  logic          owner_assigned_q;
  crbie_cmd_type cmd_q;
  crbie_cmd_type cmd_d;
  crbie_evt_type evt;
  crbie_evt_type clr;
  logic [3:0]    pend;
  logic [31:0]   status_view;
  logic          take;
  logic          wr_enable;
  logic          wr_status;
  logic          estab_armed;
  logic          ready_armed;
  logic          irq_d;
  logic          evt_owner;
  logic          evt_estab;
  logic          evt_ready;
  logic          evt_done;

  // Hsize is not checked: only whole-word transfers are expected.
  assign take      = hsel && hready && htrans[1];
  assign wr_enable = crbie_hit(req_q, OFF_ENABLE) && req_q.write;
  assign wr_status = crbie_hit(req_q, OFF_STATUS) && req_q.write;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.valid <= take;
      req_q.write <= hwrite;
      req_q.addr  <= haddr[7:0];
    end
  end

  // Zero wait states and always OKAY; hreadyout resets low and is high from the first edge after reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  // Read data is captured at the address phase edge so it stands from flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (haddr[7:0] == OFF_ENABLE) begin
        hrdata_q <= enable_q & ENABLE_MASK;
      end else if (haddr[7:0] == OFF_STATUS) begin
        hrdata_q <= status_view;
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= ENABLE_RESET;
    end else if (wr_enable) begin
      enable_q <= hwdata & ENABLE_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      owner_field_q    <= 3'h0;
      owner_assigned_q <= 1'b0;
    end else begin
      owner_field_q    <= owner_field;
      owner_assigned_q <= owner_assigned_flag;
    end
  end

  // A grant out of the unassigned state changes the field while the
  // previous assigned flag is still low, so it raises nothing.
  assign evt_owner = (owner_field != owner_field_q) && owner_assigned_q;

  crbie_armed_event u_estab (
    .clock (clock),
    .rst_n (rst_n),
    .arm   (established_reset_request),
    .done  (!established_flag),
    .armed (estab_armed),
    .fire  (evt_estab)
  );

  crbie_armed_event u_ready (
    .clock (clock),
    .rst_n (rst_n),
    .arm   (go_ready_request),
    .done  (!idle_status),
    .armed (ready_armed),
    .fire  (evt_ready)
  );

  always_comb begin
    cmd_d    = cmd_q;
    evt_done = 1'b0;
    case (cmd_q)
      CMD_IDLE: begin
        if (command_launch_write && command_launch_field == LAUNCH_CODE) begin
          cmd_d = CMD_RUN;
        end
      end
      CMD_RUN: begin
        if (command_cancel) begin
          evt_done = 1'b1;
          cmd_d    = CMD_ABORT;
        end else if (command_launch_field == LAUNCH_IDLE) begin
          evt_done = 1'b1;
          cmd_d    = CMD_IDLE;
        end
      end
      CMD_ABORT: begin
        // A cancelled command signals once; its later field clear is silent.
        if (command_launch_field == LAUNCH_IDLE) begin
          cmd_d = CMD_IDLE;
        end
      end
      default: begin
        cmd_d = CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CMD_IDLE;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // Each source has its own driver; the struct is built in one place to keep one driver.
  assign evt = {evt_owner, evt_estab, evt_ready, evt_done};

  assign clr = wr_status ? crbie_evt_type'(hwdata[3:0]) : '0;

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_pend
    crbie_sticky_bit u_pend (
      .clock (clock),
      .rst_n (rst_n),
      .set   (evt[i]),
      .clear (clr[i]),
      .pend  (pend[i])
    );
  end

  assign status_view = {28'h0000000, pend} & STATUS_MASK;

  // Flags keep latching while disabled, so enabling later fires at once.
  assign irq_d = enable_q[BIT_GLOBAL] && |(pend & enable_q[3:0]);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign irq       = irq_q;

  property p_global_off;
    @(posedge clock) disable iff (!rst_n)
      !enable_q[BIT_GLOBAL] |=> !irq;
  endproperty
  a_global_off: assert property (p_global_off) else $error("irq high with global gate off");

  property p_enable_write;
    @(posedge clock) disable iff (!rst_n)
      wr_enable |=> enable_q[3:0] == $past(hwdata[3:0]) && enable_q[30:4] == 27'h0;
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write mismatch");

  property p_reserved_read;
    @(posedge clock) disable iff (!rst_n)
      crbie_hit(req_q, OFF_STATUS) && !req_q.write |-> hrdata[31:4] == 28'h0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("status reserved bits set");

  property p_owner_evt;
    @(posedge clock) disable iff (!rst_n)
      (owner_field != $past(owner_field)) && $past(owner_assigned_flag) |=> pend[BIT_OWNER];
  endproperty
  a_owner_evt: assert property (p_owner_evt) else $error("owner change not latched");

  property p_owner_quiet;
    @(posedge clock) disable iff (!rst_n)
      !pend[BIT_OWNER] && !owner_assigned_q |=> !pend[BIT_OWNER];
  endproperty
  a_owner_quiet: assert property (p_owner_quiet) else $error("owner irq on free grant");

  property p_estab;
    @(posedge clock) disable iff (!rst_n)
      estab_armed && !established_flag |=> pend[BIT_ESTAB];
  endproperty
  a_estab: assert property (p_estab) else $error("established reset not latched");

  property p_ready;
    @(posedge clock) disable iff (!rst_n)
      ready_armed && !idle_status |=> pend[BIT_READY];
  endproperty
  a_ready: assert property (p_ready) else $error("ready transition not latched");

  property p_done;
    @(posedge clock) disable iff (!rst_n)
      cmd_q == CMD_RUN && !command_cancel && command_launch_field == LAUNCH_IDLE
      |=> pend[BIT_DONE];
  endproperty
  a_done: assert property (p_done) else $error("command done not latched");

  property p_cancel;
    @(posedge clock) disable iff (!rst_n)
      cmd_q == CMD_RUN && command_cancel |=> pend[BIT_DONE] && cmd_q == CMD_ABORT;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel not latched");

  property p_w1c_keep;
    @(posedge clock) disable iff (!rst_n)
      pend[BIT_DONE] && !(wr_status && hwdata[BIT_DONE]) |=> pend[BIT_DONE];
  endproperty
  a_w1c_keep: assert property (p_w1c_keep) else $error("status bit lost");

  property p_w1c_clear;
    @(posedge clock) disable iff (!rst_n)
      wr_status && hwdata[BIT_OWNER] && !evt.owner |=> !pend[BIT_OWNER];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear");

  property p_irq_cause;
    @(posedge clock) disable iff (!rst_n)
      irq |-> $past(enable_q[BIT_GLOBAL]) && $past(|(pend & enable_q[3:0]));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled cause");

  property p_irq_rise;
    @(posedge clock) disable iff (!rst_n)
      enable_q[BIT_GLOBAL] && enable_q[BIT_READY] && pend[BIT_READY] |=> irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("enabled pending gave no irq");

  property p_irq_off;
    @(posedge clock) disable iff (!rst_n)
      !(|(pend & enable_q[3:0])) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without pending cause");

  property p_estab_arm;
    @(posedge clock) disable iff (!rst_n)
      established_reset_request |=> estab_armed;
  endproperty
  a_estab_arm: assert property (p_estab_arm) else $error("estab request not armed");

  property p_ready_arm;
    @(posedge clock) disable iff (!rst_n)
      go_ready_request |=> ready_armed;
  endproperty
  a_ready_arm: assert property (p_ready_arm) else $error("ready request not armed");

  property p_launch;
    @(posedge clock) disable iff (!rst_n)
      cmd_q == CMD_IDLE && command_launch_write && command_launch_field == LAUNCH_CODE
      |=> cmd_q == CMD_RUN;
  endproperty
  a_launch: assert property (p_launch) else $error("launch not accepted");

  property p_launch_other;
    @(posedge clock) disable iff (!rst_n)
      cmd_q == CMD_IDLE && !(command_launch_write && command_launch_field == LAUNCH_CODE)
      |=> cmd_q == CMD_IDLE;
  endproperty
  a_launch_other: assert property (p_launch_other) else $error("stray launch accepted");

  // The command tracker must stay quiet outside a running command.
  property p_idle_quiet;
    @(posedge clock) disable iff (!rst_n)
      cmd_q == CMD_IDLE && !pend[BIT_DONE] |=> !pend[BIT_DONE];
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("done set while idle");

  property p_abort_quiet;
    @(posedge clock) disable iff (!rst_n)
      cmd_q == CMD_ABORT && !pend[BIT_DONE] |=> !pend[BIT_DONE];
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("done set after cancel");

  property p_enable_read;
    @(posedge clock) disable iff (!rst_n)
      crbie_hit(req_q, OFF_ENABLE) && !req_q.write |-> hrdata[30:4] == 27'h0;
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable reserved bits set");

  property p_w1c_zero;
    @(posedge clock) disable iff (!rst_n)
      wr_status && hwdata[3:0] == 4'h0 |=> (pend & $past(pend)) == $past(pend);
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("write zero changed status");

  c_cancel: cover property (@(posedge clock) disable iff (!rst_n)
    cmd_q == CMD_RUN && command_cancel);
  c_irq_clear: cover property (@(posedge clock) disable iff (!rst_n)
    irq && wr_status ##2 !irq);
  c_all_pend: cover property (@(posedge clock) disable iff (!rst_n)
    pend == 4'hf && estab_armed == 1'b0 && ready_armed == 1'b0);
  c_launch_done: cover property (@(posedge clock) disable iff (!rst_n)
    cmd_q == CMD_RUN && command_launch_field == LAUNCH_IDLE);
  c_owner_evt: cover property (@(posedge clock) disable iff (!rst_n)
    evt.owner && owner_assigned_flag);

endmodule

// *** tb/crb_interrupt_enable_status_tb.sv ***
// Self-checking bench for the CRB interrupt enable and status block.
`timescale 1ns/100ps
module crb_interrupt_enable_status_tb;
  import crbie_pkg::*;

  logic        clock;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  owner_field;
  logic        owner_assigned_flag;
  logic        established_flag;
  logic        established_reset_request;
  logic        go_ready_request;
  logic        idle_status;
  logic [3:0]  command_launch_field;
  logic        command_launch_write;
  logic        command_cancel;
  logic        irq;
  logic [31:0] rv;
  int          error_cnt;
  int          samples_checked;
  int          cycles;

  localparam logic [31:0] A_EN = {24'h00, OFF_ENABLE};
  localparam logic [31:0] A_ST = {24'h00, OFF_STATUS};

  crbie_irq_ctrl crbie_irq_ctrl_inst (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .owner_field(owner_field), .owner_assigned_flag(owner_assigned_flag),
    .established_flag(established_flag),
    .established_reset_request(established_reset_request),
    .go_ready_request(go_ready_request), .idle_status(idle_status),
    .command_launch_field(command_launch_field),
    .command_launch_write(command_launch_write),
    .command_cancel(command_cancel), .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The whole sequence takes under two hundred cycles; the ceiling leaves ample margin.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One single AHB-Lite transfer; the address phase is held until hready is seen high.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Irq is registered, so it is looked at in the middle of a cycle.
  task automatic irq_chk(input logic exp);
    tick(2);
    @(negedge clock);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge clock);
  endtask

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hwdata = 32'h0;
    owner_field = 3'h0;
    owner_assigned_flag = 1'b0;
    established_flag = 1'b1;
    established_reset_request = 1'b0;
    go_ready_request = 1'b0;
    idle_status = 1'b1;
    command_launch_field = 4'h0;
    command_launch_write = 1'b0;
    command_cancel = 1'b0;
    tick(16);
    rst_n <= 1'b1;
    tick(2);
    rd_chk(A_EN, 32'h0000_0000);
    rd_chk(A_ST, 32'h0000_0000);
    wr(A_EN, 32'hffff_ffff);
    rd_chk(A_EN, 32'h8000_000f);
    wr(A_ST, 32'hffff_ffff);
    rd_chk(A_ST, 32'h0000_0000);
    wr(32'h0000_0008, 32'hffff_ffff);
    rd_chk(32'h0000_0008, 32'h0000_0000);
    rd_chk(A_EN, 32'h8000_000f);
    wr(A_EN, 32'h0000_0000);
    $display("test registers done");
    // A completion level seen before any request must not latch.
    idle_status <= 1'b0;
    tick(3);
    idle_status <= 1'b1;
    tick(1);
    rd_chk(A_ST, 32'h0000_0000);
    go_ready_request <= 1'b1;
    tick(1);
    go_ready_request <= 1'b0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0000);
    idle_status <= 1'b0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0002);
    irq_chk(1'b0);
    wr(A_EN, 32'h0000_0002);
    irq_chk(1'b0);
    wr(A_EN, 32'h8000_0002);
    irq_chk(1'b1);
    wr(A_EN, 32'h8000_000d);
    irq_chk(1'b0);
    wr(A_EN, 32'h8000_0002);
    wr(A_ST, 32'h0000_0000);
    rd_chk(A_ST, 32'h0000_0002);
    wr(A_ST, 32'h0000_0002);
    rd_chk(A_ST, 32'h0000_0000);
    irq_chk(1'b0);
    idle_status <= 1'b1;
    $display("test ready and irq done");
    owner_field <= 3'h5;
    tick(3);
    rd_chk(A_ST, 32'h0000_0000);
    owner_assigned_flag <= 1'b1;
    tick(3);
    owner_field <= 3'h2;
    tick(2);
    rd_chk(A_ST, 32'h0000_0008);
    wr(A_ST, 32'h0000_0008);
    $display("test owner done");
    established_reset_request <= 1'b1;
    tick(1);
    established_reset_request <= 1'b0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0000);
    established_flag <= 1'b0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0004);
    wr(A_ST, 32'h0000_0004);
    established_flag <= 1'b1;
    $display("test established done");
    // A launch with code two instead of one must stay silent when the field clears.
    command_launch_field <= 4'h2;
    command_launch_write <= 1'b1;
    tick(1);
    command_launch_write <= 1'b0;
    tick(2);
    command_launch_field <= 4'h0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0000);
    command_launch_field <= LAUNCH_CODE;
    command_launch_write <= 1'b1;
    tick(1);
    command_launch_write <= 1'b0;
    tick(3);
    rd_chk(A_ST, 32'h0000_0000);
    command_launch_field <= 4'h0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0001);
    wr(A_ST, 32'h0000_0001);
    command_launch_field <= LAUNCH_CODE;
    command_launch_write <= 1'b1;
    tick(1);
    command_launch_write <= 1'b0;
    tick(2);
    command_cancel <= 1'b1;
    tick(1);
    command_cancel <= 1'b0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0001);
    wr(A_ST, 32'h0000_0001);
    command_launch_field <= 4'h0;
    tick(3);
    // A cancel with no command running must stay silent.
    command_cancel <= 1'b1;
    tick(1);
    command_cancel <= 1'b0;
    tick(2);
    rd_chk(A_ST, 32'h0000_0000);
    $display("test command done");
    // A reset in mid-run must drop a pending flag and the enables.
    owner_field <= 3'h6;
    tick(2);
    rd_chk(A_ST, 32'h0000_0008);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(2);
    rd_chk(A_ST, 32'h0000_0000);
    rd_chk(A_EN, 32'h0000_0000);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
